// ### vpf_pkg.sv
// Package with register map, field positions and reset values for the block.
package vpf_pkg;

    // Register addresses on the plain register port.
    localparam logic [3:0] VPF_ADDR_GEN_CTRL  = 4'h0;
    localparam logic [3:0] VPF_ADDR_FRAME_LOW = 4'h1;
    localparam logic [3:0] VPF_ADDR_FRAME_HI  = 4'h2;
    localparam logic [3:0] VPF_ADDR_PERIOD    = 4'h3;
    localparam logic [3:0] VPF_ADDR_DUTY      = 4'h4;

    // Field positions in the generator control register.
    localparam int VPF_BIT_GEN_EN  = 15;
    localparam int VPF_BIT_GEN_POL = 9;
    localparam int VPF_BIT_CNT_EN  = 8;

    // Frame number width and register field widths.
    localparam int VPF_FRAME_W     = 11;
    localparam int VPF_FRAME_LO_W  = 8;
    localparam int VPF_FRAME_HI_W  = 3;
    localparam int VPF_REG_W       = 16;
    localparam int VPF_CNT_W       = 8;

    // Reset values.
    localparam logic [15:0] VPF_RST_GEN_CTRL = 16'h0000;
    localparam logic [10:0] VPF_RST_FRAME    = 11'h000;
    localparam logic [7:0]  VPF_RST_PERIOD   = 8'hff;
    localparam logic [7:0]  VPF_RST_DUTY     = 8'h80;
    localparam logic [7:0]  VPF_RST_CNT      = 8'h00;

    // Generator states, one-hot.
    typedef enum logic [1:0] {
        VPF_GEN_IDLE = 2'b01,
        VPF_GEN_RUN  = 2'b10
    } vpf_gen_state_t;

endpackage

// ### vpf_frame_capture.sv
// Frame number holding register loaded on each received start-of-frame.
`timescale 1ns/1ns
module vpf_frame_capture
    import vpf_pkg::*;
(
    // Clock and reset.
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_rst_b,
    // Frame token input.
    input  wire logic                   i_sof_valid,
    input  wire logic [VPF_FRAME_W-1:0] i_sof_frame,
    // Held frame number.
    output logic      [VPF_FRAME_W-1:0] o_frame
);
    import vpf_pkg::*;

    logic [VPF_FRAME_W-1:0] frame_q;

    // Both register halves come from this single copy, so they always change in the same cycle.
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            frame_q <= VPF_RST_FRAME;
        end else if (i_sof_valid) begin
            frame_q <= i_sof_frame;
        end
    end

    assign o_frame = frame_q;
endmodule

// ### vpf_vbus_gen.sv
// Pulse generator driving the VBUS supply control output.
`timescale 1ns/1ns
module vpf_vbus_gen
    import vpf_pkg::*;
(
    // Clock and reset.
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_rst_b,
    // Control.
    input  wire logic                 i_enable,
    input  wire logic                 i_polarity,
    input  wire logic                 i_cnt_enable,
    input  wire logic [VPF_CNT_W-1:0] i_period,
    input  wire logic [VPF_CNT_W-1:0] i_duty,
    // Status and output.
    output logic      [VPF_CNT_W-1:0] o_count,
    output logic                      o_running,
    output logic                      o_vbus_out
);
    import vpf_pkg::*;

    vpf_gen_state_t       state_q;
    logic [VPF_CNT_W-1:0] cnt_q;
    logic                 active_q;
    logic                 out_q;

    // Run state follows the enable bit.
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= VPF_GEN_IDLE;
        end else begin
            case (state_q)
                VPF_GEN_IDLE: begin
                    if (i_enable) begin
                        state_q <= VPF_GEN_RUN;
                    end
                end
                VPF_GEN_RUN: begin
                    if (!i_enable) begin
                        state_q <= VPF_GEN_IDLE;
                    end
                end
                default: begin
                    state_q <= VPF_GEN_IDLE;
                end
            endcase
        end
    end

    // Counter runs only in run state with counter enable; clears in idle, holds in run without enable.
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q <= VPF_RST_CNT;
        end else if (state_q == VPF_GEN_IDLE) begin
            cnt_q <= VPF_RST_CNT;
        end else if (i_cnt_enable) begin
            if (cnt_q >= i_period) begin
                cnt_q <= VPF_RST_CNT;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end

    // Active phase while count is below the duty value.
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            active_q <= 1'b0;
        end else begin
            active_q <= (state_q == VPF_GEN_RUN) && (cnt_q < i_duty);
        end
    end

    // Registered pin; idle level equals polarity, so an inactive phase
    // and a disabled generator look the same on the pin.
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            out_q <= 1'b0;
        end else begin
            out_q <= active_q ^ i_polarity;
        end
    end

    assign o_count    = cnt_q;
    assign o_running  = (state_q == VPF_GEN_RUN);
    assign o_vbus_out = out_q;
endmodule

// ### vpf_top.sv
// Register bank for VBUS generator control and received frame number.
//
// Overview of operation
// - Polarity set: output active-low, held high when disabled; reset drives it low.
// - Polarity clear: output active-high, held low when disabled or reset.
// - Generator counter runs only while counter enable bit is one.
// - Eleven-bit frame number; low eight bits in frame-low bits 7 to 0.
// - Frame bits 10 to 8 appear in frame-high bits 2 to 0.
// - Each received start-of-frame token loads its number into both registers.
// - All unimplemented bits in these registers read as zero.
`timescale 1ns/1ns
module vpf_top
    import vpf_pkg::*;
(
    // Clock and reset.
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_rst_b,
    // Register port.
    input  wire logic [3:0]             i_reg_addr,
    input  wire logic [VPF_REG_W-1:0]   i_reg_wdata,
    input  wire logic                   i_reg_wr,
    input  wire logic                   i_reg_rd,
    output logic      [VPF_REG_W-1:0]   o_reg_rdata,
    // Frame token from the serial engine.
    input  wire logic                   i_sof_valid,
    input  wire logic [VPF_FRAME_W-1:0] i_sof_frame,
    // VBUS generator output.
    output logic                        o_vbus_out
);
    import vpf_pkg::*;

    logic                   rst_meta_q;
    logic                   rst_sync_q;
    logic [VPF_REG_W-1:0]   ctrl_q;
    logic [VPF_CNT_W-1:0]   period_q;
    logic [VPF_CNT_W-1:0]   duty_q;
    logic [VPF_REG_W-1:0]   rdata_q;
    logic [VPF_REG_W-1:0]   rdata_d;
    logic [VPF_FRAME_W-1:0] frame;

    // Only the three control bits are writable, others stay zero.
    localparam logic [15:0] CTRL_MASK = 16'h8300;

    // Reset is asserted at once but released in step with the clock.
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Control register write.
    always_ff @(posedge i_sys_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            ctrl_q <= VPF_RST_GEN_CTRL;
        end else if (i_reg_wr && i_reg_addr == VPF_ADDR_GEN_CTRL) begin
            ctrl_q <= i_reg_wdata & CTRL_MASK;
        end
    end

    // Period and duty registers.
    always_ff @(posedge i_sys_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            period_q <= VPF_RST_PERIOD;
            duty_q   <= VPF_RST_DUTY;
        end else if (i_reg_wr) begin
            if (i_reg_addr == VPF_ADDR_PERIOD) begin
                period_q <= i_reg_wdata[VPF_CNT_W-1:0];
            end else if (i_reg_addr == VPF_ADDR_DUTY) begin
                duty_q <= i_reg_wdata[VPF_CNT_W-1:0];
            end
        end
    end

    // Read decode; unmapped addresses and unused bits return zero.
    always_comb begin
        rdata_d = '0;
        if (i_reg_addr == VPF_ADDR_GEN_CTRL) begin
            rdata_d = ctrl_q;
        end else if (i_reg_addr == VPF_ADDR_FRAME_LOW) begin
            rdata_d = {8'h00, frame[VPF_FRAME_LO_W-1:0]};
        end else if (i_reg_addr == VPF_ADDR_FRAME_HI) begin
            rdata_d = {13'h0000, frame[VPF_FRAME_W-1:VPF_FRAME_LO_W]};
        end else if (i_reg_addr == VPF_ADDR_PERIOD) begin
            rdata_d = {8'h00, period_q};
        end else if (i_reg_addr == VPF_ADDR_DUTY) begin
            rdata_d = {8'h00, duty_q};
        end
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge i_sys_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            rdata_q <= '0;
        end else if (i_reg_rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= '0;
        end
    end

    assign o_reg_rdata = rdata_q;

    // Frame number capture.
    vpf_frame_capture u_frame (
        .i_sys_clk   (i_sys_clk),
        .i_rst_b     (rst_sync_q),
        .i_sof_valid (i_sof_valid),
        .i_sof_frame (i_sof_frame),
        .o_frame     (frame)
    );

    // VBUS generator; its count and run status are not visible to software,
    // so those outputs are left open here.
    vpf_vbus_gen u_gen (
        .i_sys_clk    (i_sys_clk),
        .i_rst_b      (rst_sync_q),
        .i_enable     (ctrl_q[VPF_BIT_GEN_EN]),
        .i_polarity   (ctrl_q[VPF_BIT_GEN_POL]),
        .i_cnt_enable (ctrl_q[VPF_BIT_CNT_EN]),
        .i_period     (period_q),
        .i_duty       (duty_q),
        .o_count      (),
        .o_running    (),
        .o_vbus_out   (o_vbus_out)
    );
endmodule

// ### vpf_top_checker.sv
// Assertion checker watching the ports of the register bank.
`timescale 1ns/1ns
module vpf_top_checker
    import vpf_pkg::*;
(
    // All top-level ports, observed only.
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_b,
    input  wire logic [3:0]  i_reg_addr,
    input  wire logic [15:0] i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [15:0] o_reg_rdata,
    input  wire logic        i_sof_valid,
    input  wire logic [10:0] i_sof_frame,
    input  wire logic        o_vbus_out
);
    import vpf_pkg::*;

    logic        en_q;
    logic        pol_q;
    logic        cnt_q;
    logic [10:0] frm_q;
    logic [15:0] ctrl_w;
    logic [15:0] lo_w;
    logic [15:0] hi_w;
    logic [2:0]  sof_hi;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    // Shadow of the writable control bits, built from the write strobes.
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            {en_q, pol_q, cnt_q} <= 3'h0;
        end else if (i_reg_wr && i_reg_addr == VPF_ADDR_GEN_CTRL) begin
            {en_q, pol_q, cnt_q} <= {i_reg_wdata[15], i_reg_wdata[9:8]};
        end
    end
    // Shadow of the frame number, loaded on every token.
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            frm_q <= 11'h000;
        end else if (i_sof_valid) begin
            frm_q <= i_sof_frame;
        end
    end
    // Expected register images; sampled one cycle back at the answer.
    assign ctrl_w = {en_q, 5'h00, pol_q, cnt_q, 8'h00};
    assign lo_w   = {8'h00, frm_q[7:0]};
    assign hi_w   = {13'h0000, frm_q[10:8]};
    assign sof_hi = i_sof_frame[10:8];
    sequence s_rd_at(logic [3:0] a);
        i_reg_rd && i_reg_addr == a;
    endsequence
    property p_ctrl;
        s_rd_at(VPF_ADDR_GEN_CTRL) |=> o_reg_rdata == $past(ctrl_w);
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("control readback wrong");
    property p_low;
        s_rd_at(VPF_ADDR_FRAME_LOW) |=> o_reg_rdata == $past(lo_w);
    endproperty
    a_low: assert property (p_low) else $error("frame low read wrong");
    property p_high;
        s_rd_at(VPF_ADDR_FRAME_HI) |=> o_reg_rdata == $past(hi_w);
    endproperty
    a_high: assert property (p_high) else $error("frame high read wrong");
    property p_sof;
        i_sof_valid ##1 s_rd_at(VPF_ADDR_FRAME_HI)
            |=> o_reg_rdata[2:0] == $past(sof_hi, 2);
    endproperty
    a_sof: assert property (p_sof) else $error("token not loaded");
    property p_pol1;
        (!en_q && pol_q) [*4] |-> o_vbus_out;
    endproperty
    a_pol1: assert property (p_pol1) else $error("idle not high");
    property p_pol0;
        (!en_q && !pol_q) [*4] |-> !o_vbus_out;
    endproperty
    a_pol0: assert property (p_pol0) else $error("idle not low");
    property p_run;
        $rose(en_q && cnt_q) |-> ##[1:600] (o_vbus_out != pol_q);
    endproperty
    a_run: assert property (p_run) else $error("never went active");
    property p_stop;
        (en_q && !cnt_q && $stable(pol_q)) [*6] |-> $stable(o_vbus_out);
    endproperty
    a_stop: assert property (p_stop) else $error("moved while stopped");
endmodule
bind vpf_top vpf_top_checker u_chk (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_sof_valid(i_sof_valid),
    .i_sof_frame(i_sof_frame), .o_vbus_out(o_vbus_out));

// ### testbench.sv
// Self-checking testbench for the generator and frame number registers.
`timescale 1ns/1ns
module testbench;
    import vpf_pkg::*;
    logic        clk;
    logic        rst_b;
    logic        wr;
    logic        rd;
    logic        sof;
    logic        vbus;
    logic        hi;
    logic        lo;
    logic        v;
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [10:0] frame;
    int          err_total;
    int          comparisons;
    logic [3:0]  ra [4] = '{4'h0, 4'h1, 4'h2, 4'hf};
    logic [10:0] fr [4] = '{11'h5a3, 11'h7ff, 11'h000, 11'h400};
    vpf_top dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
        .o_reg_rdata(rdata), .i_sof_valid(sof), .i_sof_frame(frame),
        .o_vbus_out(vbus));
    // Free-running 125 MHz clock.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic give_verdict;
        if (err_total == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        wdata <= ~d;
    endtask
    // Read data stand only in the cycle after the strobe, so look there.
    task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    // The frame lines carry junk outside the token cycle on purpose.
    task automatic send_sof(input logic [10:0] f);
        @(posedge clk);
        sof <= 1'b1;
        frame <= f;
        @(posedge clk);
        sof <= 1'b0;
        frame <= ~f;
    endtask
    // Token followed at once by a read of the high half, with no gap.
    task automatic sof_rd_hi(input logic [10:0] f);
        send_sof(f);
        addr <= VPF_ADDR_FRAME_HI;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, {13'h0000, f[10:8]});
    endtask
    task automatic watch(input int n);
        hi = 1'b0;
        lo = 1'b0;
        repeat (n) begin
            settle(1);
            if (vbus === 1'b1) hi = 1'b1;
            if (vbus === 1'b0) lo = 1'b1;
        end
    endtask
    // A hang ends the run here; the tests take about 1600 cycles.
    initial begin
        #100000;
        err_total++;
        give_verdict;
    end
    initial begin
        {rst_b, wr, rd, sof} = 4'h0;
        addr = 4'h0;
        wdata = 16'h0000;
        frame = 11'h000;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        settle(2);
        foreach (ra[i]) rd_reg(ra[i], 16'h0000);
        rd_reg(VPF_ADDR_PERIOD, {8'h00, VPF_RST_PERIOD});
        rd_reg(VPF_ADDR_DUTY, {8'h00, VPF_RST_DUTY});
        wr_reg(VPF_ADDR_GEN_CTRL, 16'hffff);
        rd_reg(VPF_ADDR_GEN_CTRL, 16'h8300);
        // Field edges of the frame number, with a refused write between.
        foreach (fr[i]) begin
            send_sof(fr[i]);
            wr_reg(VPF_ADDR_FRAME_LOW, 16'hffff);
            rd_reg(VPF_ADDR_FRAME_LOW, {8'h00, fr[i][7:0]});
            rd_reg(VPF_ADDR_FRAME_HI, {13'h0000, fr[i][10:8]});
            sof_rd_hi(~fr[i]);
        end
        wr_reg(VPF_ADDR_GEN_CTRL, 16'h0200);
        settle(4);
        chk({15'h0000, vbus}, 16'h0001);
        wr_reg(VPF_ADDR_GEN_CTRL, 16'h0000);
        settle(4);
        chk({15'h0000, vbus}, 16'h0000);
        // Running output must reach both levels in either polarity.
        for (int i = 0; i < 2; i++) begin
            wr_reg(VPF_ADDR_GEN_CTRL, i ? 16'h8300 : 16'h8100);
            watch(600);
            chk({14'h0000, hi, lo}, 16'h0003);
        end
        wr_reg(VPF_ADDR_GEN_CTRL, 16'h8000);
        settle(4);
        v = vbus;
        watch(300);
        chk({14'h0000, hi, lo}, {14'h0000, v, ~v});
        // A second reset in mid-run clears control and idles the output.
        @(posedge clk);
        rst_b <= 1'b0;
        @(posedge clk);
        rst_b <= 1'b1;
        settle(2);
        chk({15'h0000, vbus}, 16'h0000);
        rd_reg(VPF_ADDR_GEN_CTRL, 16'h0000);
        give_verdict;
    end
endmodule
